// ---- hdl/asrx_params.svh ----
// Purpose: constants for the async serial receiver with two-entry fifo
// Assumes: included by the design module, the assertion checker and the testbench
// Notes:   offsets are word addresses on the plain register port
`ifndef ASRX_PARAMS_SVH
`define ASRX_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ASRX_ADDR_W        4
`define ASRX_OFF_CTRL      4'h0
`define ASRX_OFF_STATUS    4'h1
`define ASRX_OFF_DATA      4'h2
`define ASRX_OFF_INTEN     4'h3
`define ASRX_OFF_BAUD      4'h4

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ASRX_CTRL_PORT_EN  0
`define ASRX_CTRL_CONT_RX  1
`define ASRX_CTRL_NINE_BIT 2
`define ASRX_CTRL_ADDR_DET 3

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ASRX_ST_PEND       0
`define ASRX_ST_FRAME_ERR  1
`define ASRX_ST_OVERRUN    2
`define ASRX_ST_NINTH      3

// ----------------------------------------------------------------
// interrupt enable fields
// ----------------------------------------------------------------
`define ASRX_IE_RX         0
`define ASRX_IE_PERIPH     1
`define ASRX_IE_GLOBAL     2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ASRX_CTRL_RST      4'h0
`define ASRX_IE_RST        3'h0
`define ASRX_BAUD_RST      16'h0363
`define ASRX_FIFO_DEPTH    2
`define ASRX_OVS           16
`define ASRX_OVS_HALF      8
`define ASRX_OVS_LAST      15
`define ASRX_LAST_BIT_NINE 8
`define ASRX_LAST_BIT_EIGHT 7

`endif

// ---- hdl/asrx_pkg.sv ----
// Purpose: types for the async serial receiver
// Assumes: asrx_params.svh holds the numbers
// Notes:   fifo entries travel as one packed struct
package asrx_pkg;

  // ----------------------------------------------------------------
  // fifo entry and receive states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       frameErr;
    logic [8:0] data;
  } asrx_entry_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } asrx_state_type;

endpackage : asrx_pkg

// ---- hdl/asrx_receiver.sv ----
// Purpose: receive half of an async serial unit with a two-entry fifo
// Assumes: 100 MHz ref_clk, 16x oversampling from a baud divider
// Notes:   registers on a plain port, read data one cycle after strobe
//
// Notes on behaviour
// - pending is high while enabled and an unread character sits in the fifo
// - pending is read-only and follows fifo occupancy only
// - interrupt needs rx, peripheral and global enables all set
// - pending rises regardless of any interrupt enable
// - each fifo entry keeps a framing error bit from the stop sample
// - framing error shows the oldest entry; software reads it before data
// - framing error does not stop reception and needs no clear
// - data read pops the fifo, exposing the next entry and its error
// - clearing port enable resets the unit and clears framing error
// - clearing continuous receive leaves framing error unchanged
// - framing error alone raises no interrupt
// - with all entries in error, framing error stays set until the last entry is read
// - fifo holds two; a third complete character sets overrun
// - during overrun old entries stay readable, new ones are refused
// - overrun clears when continuous receive or port enable is cleared
// - nine-bit select shifts nine data bits per character
// - ninth-bit field is msb of oldest entry; software reads it first
// - address detect keeps only ninth-bit-one characters, drops others
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "asrx_params.svh"

module asrx_receiver #(
  parameter int FIFO_DEPTH = `ASRX_FIFO_DEPTH
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    rxPin,
  input  wire logic [`ASRX_ADDR_W-1:0] regAddr,
  input  wire logic [15:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [15:0]             regRdata,
  output logic                         rxIrq
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // the line is asynchronous to ref_clk; only rxSync_r feeds logic
  logic rxMeta_r;
  logic rxSync_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end
    else
    begin
      rxMeta_r <= rxPin;
      rxSync_r <= rxMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic [3:0]  ctrl_r;
  logic [3:0]  ctrl_nxt;
  logic [2:0]  inten_r;
  logic [2:0]  inten_nxt;
  logic [15:0] baud_r;
  logic [15:0] baud_nxt;
  logic        portEn;
  logic        contRxEn;
  logic        nineBitSel;
  logic        addrDetEn;
  logic        popReq;

  assign portEn     = ctrl_r[`ASRX_CTRL_PORT_EN];
  assign contRxEn   = ctrl_r[`ASRX_CTRL_CONT_RX];
  assign nineBitSel = ctrl_r[`ASRX_CTRL_NINE_BIT];
  assign addrDetEn  = ctrl_r[`ASRX_CTRL_ADDR_DET];
  assign popReq     = regRd && (regAddr == `ASRX_OFF_DATA);

  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    inten_nxt = inten_r;
    baud_nxt  = baud_r;
    if (regWr)
    begin
      case (regAddr)
        `ASRX_OFF_CTRL:  ctrl_nxt  = regWdata[3:0];
        `ASRX_OFF_INTEN: inten_nxt = regWdata[2:0];
        `ASRX_OFF_BAUD:  baud_nxt  = regWdata;
        // status and data are read-only; writes there do nothing
        default:         ctrl_nxt  = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r  <= `ASRX_CTRL_RST;
      inten_r <= `ASRX_IE_RST;
      baud_r  <= `ASRX_BAUD_RST;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      inten_r <= inten_nxt;
      baud_r  <= baud_nxt;
    end
  end

  // ----------------------------------------------------------------
  // oversample tick divider
  // ----------------------------------------------------------------
  logic [15:0] divCnt_r;
  logic [15:0] divCnt_nxt;
  logic        tick;

  // reload on every tick so the period is exactly baud + 1 clocks
  assign tick = portEn && (divCnt_r == 16'h0000);

  always_comb
  begin
    if (!portEn || tick)
      divCnt_nxt = baud_r;
    else
      divCnt_nxt = divCnt_r - 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      divCnt_r <= 16'h0000;
    else
      divCnt_r <= divCnt_nxt;
  end

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  asrx_pkg::asrx_state_type state_r;
  asrx_pkg::asrx_state_type state_nxt;
  logic [3:0]               ovs_r;
  logic [3:0]               ovs_nxt;
  logic [3:0]               bitCnt_r;
  logic [3:0]               bitCnt_nxt;
  logic [8:0]               shift_r;
  logic [8:0]               shift_nxt;
  logic                     charDone;
  logic                     charFrameErr;
  logic [8:0]               charData;
  logic [3:0]               lastBit;

  assign lastBit = nineBitSel ? 4'(`ASRX_LAST_BIT_NINE) : 4'(`ASRX_LAST_BIT_EIGHT);

  always_comb
  begin
    state_nxt    = state_r;
    ovs_nxt      = ovs_r;
    bitCnt_nxt   = bitCnt_r;
    shift_nxt    = shift_r;
    charDone     = 1'b0;
    charFrameErr = 1'b0;
    charData     = nineBitSel ? shift_r : {1'b0, shift_r[8:1]};
    if (!portEn || !contRxEn)
      state_nxt = asrx_pkg::RX_IDLE;
    else if (tick)
    begin
      ovs_nxt = ovs_r + 4'h1;
      case (state_r)
        asrx_pkg::RX_IDLE:
        begin
          ovs_nxt = 4'h0;
          if (!rxSync_r)
            state_nxt = asrx_pkg::RX_START;
        end
        asrx_pkg::RX_START:
          if (ovs_r == 4'(`ASRX_OVS_HALF - 1))
          begin
            ovs_nxt = 4'h0;
            // glitch shorter than half a bit is not a start
            state_nxt = rxSync_r ? asrx_pkg::RX_IDLE : asrx_pkg::RX_DATA;
            bitCnt_nxt = 4'h0;
          end
        asrx_pkg::RX_DATA:
          if (ovs_r == 4'(`ASRX_OVS_LAST))
          begin
            shift_nxt  = {rxSync_r, shift_r[8:1]};
            bitCnt_nxt = bitCnt_r + 4'h1;
            if (bitCnt_r == lastBit)
              state_nxt = asrx_pkg::RX_STOP;
          end
        asrx_pkg::RX_STOP:
          if (ovs_r == 4'(`ASRX_OVS_LAST))
          begin
            charDone  = 1'b1;
            charFrameErr = !rxSync_r;
            state_nxt = asrx_pkg::RX_IDLE;
          end
        default: state_nxt = asrx_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= asrx_pkg::RX_IDLE;
      ovs_r    <= 4'h0;
      bitCnt_r <= 4'h0;
      shift_r  <= 9'h000;
    end
    else
    begin
      state_r  <= state_nxt;
      ovs_r    <= ovs_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r  <= shift_nxt;
    end
  end

  // ----------------------------------------------------------------
  // two-entry fifo and overrun
  // ----------------------------------------------------------------
  asrx_pkg::asrx_entry_type fifo_r [FIFO_DEPTH];
  asrx_pkg::asrx_entry_type fifo_nxt [FIFO_DEPTH];
  logic [1:0]               count_r;
  logic [1:0]               count_nxt;
  logic                     overrun_r;
  logic                     overrun_nxt;
  logic                     accept;
  logic                     doPop;
  asrx_pkg::asrx_entry_type head;
  logic [1:0]               wrIdx;

  // entries shift toward slot 0 so the head never moves; cheap at depth two
  assign head  = fifo_r[0];
  // a character whose ninth bit is clear is dropped in address mode
  assign accept = charDone && !(addrDetEn && !charData[8]);
  assign doPop  = popReq && (count_r != 2'h0);

  always_comb
  begin
    for (int i = 0; i < FIFO_DEPTH; i++)
      fifo_nxt[i] = fifo_r[i];
    count_nxt = count_r;
    overrun_nxt = overrun_r;
    wrIdx     = count_r;
    if (doPop)
    begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++)
        fifo_nxt[i] = fifo_r[i + 1];
      count_nxt = count_r - 2'h1;
      wrIdx     = count_r - 2'h1;
    end
    if (accept && !overrun_r)
    begin
      // a read in the same cycle frees a slot, so no overrun then
      if (wrIdx < 2'(FIFO_DEPTH))
      begin
        fifo_nxt[wrIdx[0]] = '{frameErr: charFrameErr, data: charData};
        count_nxt = wrIdx + 2'h1;
      end
      else
        // the refused character is lost; later ones are refused until a clear
        overrun_nxt = 1'b1;
    end
    if (!contRxEn || !portEn)
      overrun_nxt = 1'b0;
    if (!portEn)
      count_nxt = 2'h0;
  end

  // one flop bank per slot; the shift itself lives in the comb block above
  for (genvar g = 0; g < FIFO_DEPTH; g++)
  begin : gSlot
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        fifo_r[g] <= '0;
      else
        fifo_r[g] <= fifo_nxt[g];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r   <= 2'h0;
      overrun_r <= 1'b0;
    end
    else
    begin
      count_r   <= count_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status view, read data and interrupt
  // ----------------------------------------------------------------
  logic        pending;
  logic        frameErrView;
  logic [15:0] statusWord;
  logic [15:0] rdata_nxt;

  // contRxEn is kept out of this gate so clearing it leaves the flag alone
  assign pending      = portEn && (count_r != 2'h0);
  assign frameErrView = portEn && (count_r != 2'h0) && head.frameErr;

  always_comb
  begin
    statusWord                     = 16'h0000;
    statusWord[`ASRX_ST_PEND]      = pending;
    statusWord[`ASRX_ST_FRAME_ERR] = frameErrView;
    statusWord[`ASRX_ST_OVERRUN]   = overrun_r;
    statusWord[`ASRX_ST_NINTH]     = pending && head.data[8];
  end

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (regRd)
    begin
      case (regAddr)
        `ASRX_OFF_CTRL:   rdata_nxt = {12'h000, ctrl_r};
        `ASRX_OFF_STATUS: rdata_nxt = statusWord;
        `ASRX_OFF_DATA:   rdata_nxt = pending ? {8'h00, head.data[7:0]} : 16'h0000;
        `ASRX_OFF_INTEN:  rdata_nxt = {13'h0000, inten_r};
        `ASRX_OFF_BAUD:   rdata_nxt = baud_r;
        default:          rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 16'h0000;
    else
      regRdata <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  logic irq_nxt;

  always_comb
  begin
    // framing error is not part of this term
    irq_nxt = pending && inten_r[`ASRX_IE_RX] && inten_r[`ASRX_IE_PERIPH]
              && inten_r[`ASRX_IE_GLOBAL];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rxIrq <= 1'b0;
    else
      rxIrq <= irq_nxt;
  end

endmodule : asrx_receiver

`default_nettype wire

// ---- verification/asrx_receiver_asserts.sv ----
// Purpose: port-level checks for the async serial receiver
// Assumes: strobes never overlap; shadows mirror software writes
// Notes:   bound to every asrx_receiver instance
`timescale 1ns/1ps
`default_nettype none
`include "asrx_params.svh"

module asrx_receiver_chk #(
  parameter int FIFO_DEPTH = `ASRX_FIFO_DEPTH
) (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    rxPin,
  input wire logic [`ASRX_ADDR_W-1:0] regAddr,
  input wire logic [15:0]             regWdata,
  input wire logic                    regWr,
  input wire logic                    regRd,
  input wire logic [15:0]             regRdata,
  input wire logic                    rxIrq
);
  logic [3:0] ctrlSh_r;
  logic [3:0] ctrlSh_nxt;
  logic [2:0] ieSh_r;
  logic [2:0] ieSh_nxt;

  always_comb
  begin
    ctrlSh_nxt = ctrlSh_r;
    ieSh_nxt   = ieSh_r;
    if (regWr && regAddr == `ASRX_OFF_CTRL)
      ctrlSh_nxt = regWdata[3:0];
    if (regWr && regAddr == `ASRX_OFF_INTEN)
      ieSh_nxt = regWdata[2:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlSh_r <= `ASRX_CTRL_RST;
      ieSh_r   <= `ASRX_IE_RST;
    end
    else
    begin
      ctrlSh_r <= ctrlSh_nxt;
      ieSh_r   <= ieSh_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rd_idle_a: assert property (!regRd |=> regRdata == 16'h0000)
    else $error("read data not zero outside a read");
  irq_gate_a: assert property (rxIrq |-> $past(ieSh_r) == 3'h7)
    else $error("irq without all three enables");
  irq_off_a: assert property (rxIrq |-> $past(ctrlSh_r[`ASRX_CTRL_PORT_EN]))
    else $error("irq while port disabled");
  unmap_rd_a: assert property (regRd && regAddr > `ASRX_OFF_BAUD |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  ctrl_rb_a: assert property (regRd && regAddr == `ASRX_OFF_CTRL
    |=> regRdata[3:0] == $past(ctrlSh_r)) else $error("control readback wrong");
  ien_rb_a: assert property (regRd && regAddr == `ASRX_OFF_INTEN
    |=> regRdata[2:0] == $past(ieSh_r)) else $error("enable readback wrong");
  st_off_a: assert property (regRd && regAddr == `ASRX_OFF_STATUS && !ctrlSh_r[0]
    && !$past(ctrlSh_r[0]) |=> regRdata[1:0] == 2'b00) else $error("status set while off");
  ovr_clr_a: assert property (regRd && regAddr == `ASRX_OFF_STATUS && !ctrlSh_r[1]
    && !$past(ctrlSh_r[1]) |=> !regRdata[`ASRX_ST_OVERRUN]) else $error("overrun not cleared");
endmodule : asrx_receiver_chk

bind asrx_receiver asrx_receiver_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .rxPin(rxPin), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIrq(rxIrq));
`default_nettype wire

// ---- verification/asrx_serial_tx.sv ----
// Purpose: remote serial transmitter driving the receive line
// Assumes: line idles high, lsb first, one stop bit
// Notes:   a bad stop drives the stop bit low on purpose
`timescale 1ns/1ps
`default_nettype none

module asrx_serial_tx #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic ref_clk,
  output var logic  rxPin
);
  initial rxPin = 1'b1;

  task automatic send(
    input logic [8:0] d,
    input logic       nine,
    input logic       badStop,
    input int         gapBits
  );
    int n;
    n = nine ? 9 : 8;
    @(posedge ref_clk);
    rxPin <= 1'b0;
    repeat (BIT_CLKS) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      rxPin <= d[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rxPin <= ~badStop;
    repeat (BIT_CLKS) @(posedge ref_clk);
    rxPin <= 1'b1;  // released line idles high
    repeat (gapBits * BIT_CLKS) @(posedge ref_clk);
  endtask : send
endmodule : asrx_serial_tx
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the async serial receiver
// Assumes: baud divider written to 0, so one bit is 16 clocks
// Notes:   ordinary frames come from a row table
`timescale 1ns/1ps
`default_nettype none
`include "asrx_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end

module testbench;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [8:0] d;
    logic       bad;
    logic [3:0] st;
    logic [7:0] dat;
  } asrx_row_type;

  logic                    ref_clk;
  logic                    rst_n;
  wire logic               rxPin;
  logic [`ASRX_ADDR_W-1:0] regAddr;
  logic [15:0]             regWdata;
  logic                    regWr;
  logic                    regRd;
  logic [15:0]             regRdata;
  logic                    rxIrq;
  int                      num_errors;
  int                      tests_run;
  asrx_row_type            rows [7] = '{
    '{4'h3, 9'h0A5, 1'b0, 4'h1, 8'hA5},
    '{4'h3, 9'h05A, 1'b1, 4'h3, 8'h5A},
    '{4'h7, 9'h1C3, 1'b0, 4'h9, 8'hC3},
    '{4'h7, 9'h03C, 1'b0, 4'h1, 8'h3C},
    '{4'hF, 9'h142, 1'b0, 4'h9, 8'h42},
    '{4'h7, 9'h042, 1'b0, 4'h1, 8'h42},
    '{4'hF, 9'h042, 1'b0, 4'h0, 8'h00}};

  asrx_receiver i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .rxPin(rxPin), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIrq(rxIrq));
  asrx_serial_tx i_tx (.ref_clk(ref_clk), .rxPin(rxPin));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [`ASRX_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [`ASRX_ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    @(negedge ref_clk);
    `CHK(regRdata & m, e)
  endtask : rd

  task automatic final_report;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end

  initial
  begin
    num_errors = 0;
    tests_run  = 0;
    rst_n      = 1'b0;
    regAddr    = '0;
    regWdata   = '0;
    regWr      = 1'b0;
    regRd      = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`ASRX_OFF_CTRL, 16'hFFFF, 16'h0000);
    rd(`ASRX_OFF_INTEN, 16'hFFFF, 16'h0000);
    rd(`ASRX_OFF_BAUD, 16'hFFFF, `ASRX_BAUD_RST);
    rd(4'hF, 16'hFFFF, 16'h0000);
    wr(`ASRX_OFF_BAUD, 16'h0000);
    foreach (rows[i])
    begin
      wr(`ASRX_OFF_CTRL, {12'h000, rows[i].ctrl});
      i_tx.send(rows[i].d, rows[i].ctrl[`ASRX_CTRL_NINE_BIT], rows[i].bad, i % 3);
      rd(`ASRX_OFF_STATUS, 16'h000F, {12'h000, rows[i].st});
      rd(`ASRX_OFF_DATA, 16'h00FF, {8'h00, rows[i].dat});
      rd(`ASRX_OFF_STATUS, 16'h0001, 16'h0000);
    end
    // third frame lands on a full fifo
    wr(`ASRX_OFF_CTRL, 16'h0003);
    i_tx.send(9'h011, 1'b0, 1'b1, 1);
    i_tx.send(9'h022, 1'b0, 1'b0, 0);
    i_tx.send(9'h033, 1'b0, 1'b0, 0);
    rd(`ASRX_OFF_STATUS, 16'h000F, 16'h0007);
    rd(`ASRX_OFF_DATA, 16'h00FF, 16'h0011);
    rd(`ASRX_OFF_STATUS, 16'h000F, 16'h0005);
    rd(`ASRX_OFF_DATA, 16'h00FF, 16'h0022);
    i_tx.send(9'h044, 1'b0, 1'b0, 1);
    rd(`ASRX_OFF_STATUS, 16'h000F, 16'h0004);
    wr(`ASRX_OFF_CTRL, 16'h0001);
    rd(`ASRX_OFF_STATUS, 16'h0004, 16'h0000);
    wr(`ASRX_OFF_CTRL, 16'h0003);
    i_tx.send(9'h066, 1'b0, 1'b1, 1);
    i_tx.send(9'h077, 1'b0, 1'b1, 1);
    rd(`ASRX_OFF_DATA, 16'h00FF, 16'h0066);
    rd(`ASRX_OFF_STATUS, 16'h0002, 16'h0002);
    wr(`ASRX_OFF_CTRL, 16'h0001);
    rd(`ASRX_OFF_STATUS, 16'h0002, 16'h0002);
    wr(`ASRX_OFF_CTRL, 16'h0000);
    rd(`ASRX_OFF_STATUS, 16'h000F, 16'h0000);
    wr(`ASRX_OFF_CTRL, 16'h0003);
    rd(`ASRX_OFF_STATUS, 16'h0001, 16'h0000);
    wr(`ASRX_OFF_STATUS, 16'h000F);
    rd(`ASRX_OFF_STATUS, 16'h000F, 16'h0000);
    wr(`ASRX_OFF_INTEN, 16'h0003);
    i_tx.send(9'h05A, 1'b0, 1'b0, 1);
    rd(`ASRX_OFF_STATUS, 16'h0001, 16'h0001);
    `CHK(rxIrq, 1'b0)
    wr(`ASRX_OFF_INTEN, 16'h0007);
    repeat (3) @(negedge ref_clk);
    `CHK(rxIrq, 1'b1)
    rd(`ASRX_OFF_DATA, 16'h00FF, 16'h005A);
    repeat (3) @(negedge ref_clk);
    `CHK(rxIrq, 1'b0)
    // reset in mid-run with a character waiting and the irq up
    i_tx.send(9'h0A5, 1'b0, 1'b0, 1);
    @(negedge ref_clk);
    `CHK(rxIrq, 1'b1)
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(negedge ref_clk);
    `CHK(rxIrq, 1'b0)
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`ASRX_OFF_CTRL, 16'hFFFF, 16'h0000);
    rd(`ASRX_OFF_STATUS, 16'h000F, 16'h0000);
    rd(`ASRX_OFF_BAUD, 16'hFFFF, `ASRX_BAUD_RST);
    final_report;
  end
endmodule : testbench
`default_nettype wire
